// File: cmp_pkg.sv
// Register map, field layout and timing constants for the comparator control block
`default_nettype none
package cmp_pkg;
  localparam int unsigned        NUM_CMP         = 2;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]         CMP_A_CTRL_IDX  = 8'h9e;
  localparam logic [7:0]         CMP_B_CTRL_IDX  = 8'h9f;
  localparam logic [7:0]         IRQ_STAT_IDX    = 8'ha0;
  localparam logic [7:0]         IRQ_MASK_IDX    = 8'ha1;
  localparam logic [9:0]         CMP_A_CTRL_ADDR = 10'h278;
  localparam logic [9:0]         CMP_B_CTRL_ADDR = 10'h27c;
  localparam logic [9:0]         IRQ_STAT_ADDR   = 10'h280;
  localparam logic [9:0]         IRQ_MASK_ADDR   = 10'h284;
  localparam logic [7:0]         CTRL_RESET      = 8'h00;
  localparam logic [3:0]         IRQ_RESET       = 4'h0;
  localparam int unsigned        ON_BIT          = 7;
  localparam int unsigned        RESULT_BIT      = 6;
  localparam int unsigned        RISE_BIT        = 5;
  localparam int unsigned        FALL_BIT        = 4;
  localparam int unsigned        POS_HYST_LSB    = 2;
  localparam int unsigned        NEG_HYST_LSB    = 0;
  localparam logic [31:0]        UNMAPPED_DATA   = 32'h0000_0000;
  localparam int unsigned        SETTLE_US       = 20;
  localparam int unsigned        CLK_MHZ         = 125;
  localparam int unsigned        SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage
`default_nettype wire

// File: cmp_channel.sv
// One comparator channel: input synchroniser, enable gating and sticky edge flags
`default_nettype none
module cmp_channel
  import cmp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       on_i,
  input  wire logic       raw_i,
  input  wire logic       clr_rise_i,
  input  wire logic       clr_fall_i,
  output logic            result_o,
  output logic            rise_flag_o,
  output logic            fall_flag_o
);
  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       seen;
  wire        agreed  = (sync2 == sync3);
  wire        rise_ev = on_i & agreed & sync3 & ~seen;
  wire        fall_ev = on_i & agreed & ~sync3 & seen;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (ce_i) begin
      sync1 <= raw_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Disabled channels read low, so enabling into a high input counts as a rise
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen <= 1'b0;
    end else if (ce_i) begin
      if (!on_i) begin
        seen <= 1'b0;
      end else if (agreed) begin
        seen <= sync3;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_flag_o <= 1'b0;
      fall_flag_o <= 1'b0;
    end else if (ce_i) begin
      rise_flag_o <= rise_ev | (rise_flag_o & ~clr_rise_i);
      fall_flag_o <= fall_ev | (fall_flag_o & ~clr_fall_i);
    end
  end

  assign result_o = seen;

  rise_sets_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && rise_ev |=> rise_flag_o) else $error("rise event did not set flag");
  fall_sets_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && fall_ev |=> fall_flag_o) else $error("fall event did not set flag");
  off_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && !on_i |=> !result_o) else $error("disabled channel output not low");
  flag_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rise_flag_o && !clr_rise_i |=> rise_flag_o) else $error("rise flag dropped");
endmodule
`default_nettype wire

// File: cmp_ctrl.sv
// Avalon-MM register block for two comparators with edge flags and interrupt
`default_nettype none
// What this block does
// - Control bit 7 powers each comparator on when 1 and shuts it down when 0.
// - Bit 6 reads the synchronised comparator result, 1 when plus exceeds minus.
// - Bit 5 is set by a rising output edge and stays until software clears it.
// - Bit 4 is set by a falling output edge and stays until software clears it.
// - Bits 3 to 2 select positive hysteresis, driven to the analog core.
// - Bits 1 to 0 select negative hysteresis with the same coding.
// - The first comparator register sits at index 0x9e and resets to zero.
// - The second comparator register sits at index 0x9f and resets to zero.
// - A disabled comparator holds its port output low and detects no edges.
// - Edge flags clear only by a software write of 0, never by hardware.
// - Only the first comparator drives the reset-source output.
module cmp_ctrl
  import cmp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cmp_a_raw_i,
  input  wire logic        cmp_b_raw_i,
  output logic             cmp_a_on_o,
  output logic             cmp_b_on_o,
  output logic [1:0]       cmp_a_pos_hyst_o,
  output logic [1:0]       cmp_a_neg_hyst_o,
  output logic [1:0]       cmp_b_pos_hyst_o,
  output logic [1:0]       cmp_b_neg_hyst_o,
  output logic             cmp_a_port_o,
  output logic             cmp_b_port_o,
  output logic             cmp_a_reset_src_o,
  output logic [1:0]       cmp_irq_o,
  output logic             irq_o
);
  bus_state_t  state;
  bus_state_t  next_state;
  logic [5:0]  cfg [NUM_CMP];
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [31:0] rdata;
  logic [NUM_CMP-1:0] on;
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] rise;
  logic [NUM_CMP-1:0] fall;
  logic [NUM_CMP-1:0] rise_d;
  logic [NUM_CMP-1:0] fall_d;
  logic [NUM_CMP-1:0] raw;
  logic [7:0]  ctrl_view [NUM_CMP];

  // Every access takes one wait cycle, then completes in BUS_ACK
  wire         req       = avs_read_i | avs_write_i;
  wire         done      = (state == BUS_ACK);
  wire         wr_lane0  = avs_write_i & done & avs_byteenable_i[0];
  wire         hit_a     = (avs_address_i == CMP_A_CTRL_ADDR);
  wire         hit_b     = (avs_address_i == CMP_B_CTRL_ADDR);
  wire         hit_stat  = (avs_address_i == IRQ_STAT_ADDR);
  wire         hit_mask  = (avs_address_i == IRQ_MASK_ADDR);
  wire [1:0]   hit_ctrl  = {hit_b, hit_a};
  wire [7:0]   wbyte     = avs_writedata_i[7:0];
  wire [3:0]   new_ev    = {fall & ~fall_d, rise & ~rise_d};

  assign raw = {cmp_b_raw_i, cmp_a_raw_i};

  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (req) begin
          next_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        next_state = BUS_IDLE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BUS_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign avs_waitrequest_o = ~done;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : gen_ch
      wire wr_ctrl = wr_lane0 & hit_ctrl[g];

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cfg[g] <= CTRL_RESET[5:0];
        end else if (ce_i && wr_ctrl) begin
          cfg[g] <= {wbyte[ON_BIT], wbyte[POS_HYST_LSB+1 -: 2], wbyte[NEG_HYST_LSB+1 -: 2], 1'b0};
        end
      end

      assign on[g] = cfg[g][5];

      cmp_channel u_ch (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .on_i        (on[g]),
        .raw_i       (raw[g]),
        .clr_rise_i  (wr_ctrl & ~wbyte[RISE_BIT]),
        .clr_fall_i  (wr_ctrl & ~wbyte[FALL_BIT]),
        .result_o    (result[g]),
        .rise_flag_o (rise[g]),
        .fall_flag_o (fall[g])
      );

      assign ctrl_view[g] = {on[g], result[g], rise[g], fall[g], cfg[g][4:1]};
      assign cmp_irq_o[g] = rise[g] | fall[g];
    end
  endgenerate

  assign cmp_a_on_o        = on[0];
  assign cmp_b_on_o        = on[1];
  assign cmp_a_pos_hyst_o  = cfg[0][4:3];
  assign cmp_a_neg_hyst_o  = cfg[0][2:1];
  assign cmp_b_pos_hyst_o  = cfg[1][4:3];
  assign cmp_b_neg_hyst_o  = cfg[1][2:1];
  assign cmp_a_port_o      = result[0] & on[0];
  assign cmp_b_port_o      = result[1] & on[1];
  assign cmp_a_reset_src_o = cmp_a_port_o;

  // Status bits 0..1 are rise events, 2..3 fall events, per comparator
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_d <= '0;
      fall_d <= '0;
    end else if (ce_i) begin
      rise_d <= rise;
      fall_d <= fall;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= IRQ_RESET;
    end else if (ce_i) begin
      irq_stat <= new_ev | (irq_stat & ~((wr_lane0 & hit_stat) ? wbyte[3:0] : 4'h0));
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= IRQ_RESET;
    end else if (ce_i && wr_lane0 && hit_mask) begin
      irq_mask <= wbyte[3:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Unmapped reads return zero; writes there are dropped
  always_comb begin
    rdata = UNMAPPED_DATA;
    if (hit_a) begin
      rdata = {24'h00_0000, ctrl_view[0]};
    end else if (hit_b) begin
      rdata = {24'h00_0000, ctrl_view[1]};
    end else if (hit_stat) begin
      rdata = {28'h000_0000, irq_stat};
    end else if (hit_mask) begin
      rdata = {28'h000_0000, irq_mask};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= UNMAPPED_DATA;
    end else if (ce_i && state == BUS_IDLE && avs_read_i) begin
      avs_readdata_o <= rdata;
    end
  end

  sequence wr_on_a_s;
    ce_i && wr_lane0 && hit_a && wbyte[ON_BIT];
  endsequence
  sequence wr_off_a_s;
    ce_i && wr_lane0 && hit_a && !wbyte[ON_BIT];
  endsequence

  enable_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_on_a_s |=> cmp_a_on_o) else $error("enable write not applied");
  disable_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_off_a_s |=> !cmp_a_on_o && !cmp_a_port_o) else $error("disable not applied");
  hyst_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && wr_lane0 && hit_b |=> cmp_b_pos_hyst_o == $past(wbyte[3:2])
      && cmp_b_neg_hyst_o == $past(wbyte[1:0])) else $error("hysteresis mismatch");
  cmp_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_irq_o[1] == (rise[1] | fall[1])) else $error("per-channel irq wrong");
  reset_src_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_a_reset_src_o == (result[0] && on[0])) else $error("reset source wrong");
  one_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && state == BUS_IDLE && req |=> !avs_waitrequest_o) else $error("answer late");
  read_view_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && state == BUS_IDLE && avs_read_i && hit_a |=> avs_readdata_o[7:0] == $past(ctrl_view[0]))
    else $error("control read data wrong");
endmodule
`default_nettype wire

// File: cmp_analog_model.sv
// Behavioural analog comparator core driving one raw output into the block
`default_nettype none
module cmp_analog_model
  import cmp_pkg::*;
#(
  parameter int unsigned SETTLE = SETTLE_CYCLES
)
(
  input  wire logic mclk_i,
  input  wire logic on_i,
  input  wire logic above_i,
  output logic      raw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_q;
  initial raw_o = 1'b0;
  initial wait_q = 0;
  // Unpowered or still settling: output chatters, so the gating must hide it
  always @(posedge mclk_i) begin
    if (!on_i) wait_q <= SETTLE;
    else if (wait_q != 0) wait_q <= wait_q - 1;
    if (!on_i || wait_q != 0) raw_o <= ~raw_o;
    else raw_o <= above_i;
  end
endmodule
`default_nettype wire

// File: dual_comparator_control_test.sv
// Self-checking bench for the two-comparator control block
`default_nettype none
module dual_comparator_control_test
  import cmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, rst_n_i = 0, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [9:0]  avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = '0;
  logic        avs_waitrequest_o, cmp_a_raw_i, cmp_b_raw_i, cmp_a_on_o, cmp_b_on_o;
  logic [1:0]  cmp_a_pos_hyst_o, cmp_a_neg_hyst_o, cmp_b_pos_hyst_o, cmp_b_neg_hyst_o;
  logic        cmp_a_port_o, cmp_b_port_o, cmp_a_reset_src_o, irq_o;
  logic [1:0]  cmp_irq_o;
  logic        above_a = 0, above_b = 0;
  int          err_count = 0, n_checks = 0;

  always #4 mclk_i = ~mclk_i;

  cmp_ctrl dut (.mclk_i, .rst_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .cmp_a_raw_i, .cmp_b_raw_i, .cmp_a_on_o, .cmp_b_on_o, .cmp_a_pos_hyst_o,
    .cmp_a_neg_hyst_o, .cmp_b_pos_hyst_o, .cmp_b_neg_hyst_o, .cmp_a_port_o,
    .cmp_b_port_o, .cmp_a_reset_src_o, .cmp_irq_o, .irq_o);
  cmp_analog_model ma (.mclk_i, .on_i(cmp_a_on_o), .above_i(above_a), .raw_o(cmp_a_raw_i));
  cmp_analog_model mb (.mclk_i, .on_i(cmp_b_on_o), .above_i(above_b), .raw_o(cmp_b_raw_i));

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held from launch edge until the edge where waitrequest is seen low
  // Only the watchdog ends a wait that never completes
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be = 4'h1);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    bus(1'b0, a, '0, 4'hf, q);
    chk(q & m, e);
  endtask

  task automatic t_reset;
    rd(CMP_A_CTRL_ADDR, 32'h0);
    rd(CMP_B_CTRL_ADDR, 32'h0);
    rd(IRQ_STAT_ADDR, 32'h0);
    rd(IRQ_MASK_ADDR, 32'h0);
    wr(10'h3fc, 32'hff);
    rd(10'h3fc, 32'h0);
    chk({cmp_a_on_o, cmp_b_on_o, cmp_a_port_o, cmp_b_port_o, irq_o, cmp_irq_o}, 0);
    $display("test reset done");
  endtask

  task automatic t_hyst;
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {4'h0, c[1:0], 2'(3 - c)};
      wr(CMP_A_CTRL_ADDR, {24'h0, v});
      wr(CMP_B_CTRL_ADDR, {24'h0, v});
      rd(CMP_A_CTRL_ADDR, {24'h0, v});
      chk({cmp_a_pos_hyst_o, cmp_a_neg_hyst_o}, v[3:0]);
      chk({cmp_b_pos_hyst_o, cmp_b_neg_hyst_o}, v[3:0]);
    end
    // Writes without lane 0 must be dropped
    wr(CMP_A_CTRL_ADDR, 32'h8f, 4'he);
    rd(CMP_A_CTRL_ADDR, 32'h0c);
    $display("test hysteresis done");
  endtask

  task automatic t_a;
    wr(CMP_A_CTRL_ADDR, 32'h80);
    repeat (SETTLE_CYCLES + 20) @(negedge mclk_i);
    chk(cmp_a_on_o, 1);
    wr(CMP_A_CTRL_ADDR, 32'h80);
    wr(IRQ_STAT_ADDR, 32'hf);
    rd(CMP_A_CTRL_ADDR, 32'h80);
    @(posedge mclk_i) above_a <= 1'b1;
    repeat (10) @(negedge mclk_i);
    rd(CMP_A_CTRL_ADDR, 32'he0);
    chk({cmp_a_port_o, cmp_a_reset_src_o, cmp_irq_o}, 4'hd);
    @(posedge mclk_i) above_a <= 1'b0;
    repeat (10) @(negedge mclk_i);
    rd(CMP_A_CTRL_ADDR, 32'hb0);
    wr(CMP_A_CTRL_ADDR, 32'hb0);
    rd(CMP_A_CTRL_ADDR, 32'hb0);
    wr(CMP_A_CTRL_ADDR, 32'h90);
    rd(CMP_A_CTRL_ADDR, 32'h90);
    wr(CMP_A_CTRL_ADDR, 32'h80);
    rd(CMP_B_CTRL_ADDR, 32'h0c, ~32'h40);
    chk({cmp_b_port_o, cmp_irq_o, irq_o}, 0);
    rd(IRQ_STAT_ADDR, 32'h5);
    wr(IRQ_MASK_ADDR, 32'h1);
    repeat (3) @(negedge mclk_i);
    chk(irq_o, 1);
    wr(IRQ_STAT_ADDR, 32'h1);
    repeat (3) @(negedge mclk_i);
    chk(irq_o, 0);
    rd(IRQ_STAT_ADDR, 32'h4);
    $display("test comparator a done");
  endtask

  task automatic t_b;
    wr(CMP_B_CTRL_ADDR, 32'h80);
    repeat (SETTLE_CYCLES + 20) @(negedge mclk_i);
    wr(CMP_B_CTRL_ADDR, 32'h80);
    wr(IRQ_STAT_ADDR, 32'hf);
    @(posedge mclk_i) above_b <= 1'b1;
    repeat (10) @(negedge mclk_i);
    rd(CMP_B_CTRL_ADDR, 32'he0);
    chk({cmp_b_port_o, cmp_a_reset_src_o, cmp_irq_o, irq_o}, 5'h14);
    wr(IRQ_MASK_ADDR, 32'h2);
    repeat (3) @(negedge mclk_i);
    chk(irq_o, 1);
    wr(CMP_B_CTRL_ADDR, 32'h20);
    @(posedge mclk_i) above_b <= 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(cmp_b_port_o, 0);
    rd(CMP_B_CTRL_ADDR, 32'h20, ~32'h40);
    $display("test comparator b done");
  endtask

  // Two settling waits dominate the run; this leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_hyst;
    t_a;
    t_b;
    end_of_test;
  end
endmodule
`default_nettype wire
